// file: epirq_params.svh
// Register offsets, field positions, reset values and widths for the pin interrupt flag block
`ifndef EPIRQ_PARAMS_SVH
`define EPIRQ_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------
`define EPIRQ_ADDR_W 5
`define EPIRQ_OFS_PORT_SENSE 5'h00
`define EPIRQ_OFS_EXT_SENSE 5'h04
`define EPIRQ_OFS_PIN_ENABLE 5'h08
`define EPIRQ_OFS_EXT_FLAGS 5'h0C
`define EPIRQ_OFS_MOD_FLAGS 5'h10
`define EPIRQ_OFS_IRQ_STATUS 5'h14
`define EPIRQ_OFS_IRQ_MASK 5'h18

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define EPIRQ_GRP_LOW_BIT 7
`define EPIRQ_GRP_HIGH_BIT 6
`define EPIRQ_NUM_PORT 16
`define EPIRQ_NUM_EXT 6
`define EPIRQ_RST_16 16'h0000
`define EPIRQ_RST_12 12'h000
`define EPIRQ_RST_8 8'h00
`define EPIRQ_RST_6 6'h00

`endif

// file: epirq_pkg.sv
// Types shared by the pin interrupt flag block
package epirq_pkg;

    // Sense selection of one external request pin
    typedef enum logic [1:0]
    {
        EPIRQ_FALL = 2'h0,
        EPIRQ_RISE = 2'h1,
        EPIRQ_LOW = 2'h2,
        EPIRQ_RSVD = 2'h3
    } epirq_sense_e;

    // Edge or level detection
    function automatic logic epirq_is_edge(input logic [1:0] sel);
        return (sel == EPIRQ_FALL) || (sel == EPIRQ_RISE);
    endfunction

endpackage

// file: epirq_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module epirq_sync
    import epirq_pkg::*;
#(
    parameter int W = 1
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pins in, synchronised out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta; // First stage, read only by the second

    // ----------------------------------------------------------------
    // Two stages
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Idle-high level, so no false falling edge follows reset
            meta <= '1;
            sync_out <= '1;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// file: epirq_ext_det.sv
// Edge or level detector with latched flag for one external request pin
`timescale 1ns/1ps
`include "epirq_params.svh"
module epirq_ext_det
    import epirq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Synchronised pin and its sense selection
    input wire logic pin,
    input wire logic [1:0] sense,
    // Clear request from software
    input wire logic clear,
    // Latched flag
    output logic flag
);

    logic pin_d; // Previous sample for edge detection
    logic hit; // Detection this cycle

    // ----------------------------------------------------------------
    // Detection
    // ----------------------------------------------------------------
    always_comb
    begin
        unique case (sense)
            EPIRQ_FALL: hit = pin_d & ~pin;
            EPIRQ_RISE: hit = ~pin_d & pin;
            EPIRQ_LOW: hit = ~pin;
            EPIRQ_RSVD: hit = 1'b0; // Reserved code never requests
        endcase
    end

    // Previous pin level
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_d <= 1'b1;
        else
            pin_d <= pin;
    end

    // Flag: a new detection wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            flag <= 1'b0;
        else if (hit)
            flag <= 1'b1;
        else if (clear || !epirq_is_edge(sense))
            flag <= 1'b0; // Level mode follows the pin once it is gone
    end

endmodule

// file: epirq_top.sv
// Pin enable and request flag registers of the interrupt controller
// Operation
// R01: Enable bit n gates port pin n
// R02: Enable register resets to zero
// R03: Software zeroes enables of unused pins
// R04: Eight-bit flag register, group bits read-only
// R05: Bit 7 flags port pins 0-7
// R06: Bit 6 flags port pins 8-15
// R07: Bits 5-0 flag external pins 5-0
// R08: Only zero writes clear external flags
// R09: Software reads one before writing zero
// R10: Zero write cancels latched edge request
// R11: Module flag register is read-only
// R12: Bits 3-0 show DMA channel end
// R13: Bits 7-4 show infrared requests
// R14: Flag registers reset to zero
// R15: Port sense bit selects low or high
// R16: External sense: fall, rise, low, reserved
// R17: Group flag ORs enabled matching pins
// R18: Module flag follows source request line
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "epirq_params.svh"
module epirq_top
    import epirq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [`EPIRQ_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Interrupt pins from outside
    input wire logic [`EPIRQ_NUM_PORT-1:0] port_interrupt_pins,
    input wire logic [`EPIRQ_NUM_EXT-1:0] ext_request_pins,
    // Request lines from on-chip modules, same clock
    input wire logic [3:0] dma_end_req,
    input wire logic ir_transmit_req,
    input wire logic ir_break_req,
    input wire logic ir_receive_req,
    input wire logic ir_error_req,
    // Interrupt output
    output logic irq
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    // Registers
    logic [15:0] port_pin_irq_enable; // Per-pin gate
    logic [15:0] port_sense_control; // Per-pin level polarity
    logic [11:0] ext_sense_control; // Two bits per external pin
    logic [7:0] module_request_flags; // Read-only module flags
    logic [7:0] ext_pin_request_flags; // Assembled view
    logic [7:0] irq_status; // Sticky event bits
    logic [7:0] irq_mask; // Gates status onto irq

    // Pin side
    logic [15:0] port_sync; // Synchronised port pins
    logic [5:0] ext_sync; // Synchronised external pins
    logic [5:0] ext_pin_flags; // Latched external flags
    logic [5:0] ext_clear; // Zero-write clear per flag
    logic [15:0] port_active; // Enabled pins in request state
    logic port_group_low_flag; // Pins 0-7
    logic port_group_high_flag; // Pins 8-15

    // Events
    logic [7:0] prev_ext_view; // For rising edge events
    logic [7:0] prev_mod_view;
    logic [7:0] next_irq_status;

    // Write strobes
    logic wr_ext; // Write to external flag register
    logic wr_enable; // Enable register
    logic wr_psense; // Port sense bits
    logic wr_esense; // External sense fields
    logic wr_mask; // Interrupt mask
    logic wr_status; // Status clear

    // One compare for all registers keeps each offset in one place
    function automatic logic epirq_reg_hit(input logic strobe,
        input logic [`EPIRQ_ADDR_W-1:0] addr, input logic [`EPIRQ_ADDR_W-1:0] ofs);
        return strobe && (addr == ofs);
    endfunction

    assign wr_enable = epirq_reg_hit(reg_wr, reg_addr, `EPIRQ_OFS_PIN_ENABLE);
    assign wr_psense = epirq_reg_hit(reg_wr, reg_addr, `EPIRQ_OFS_PORT_SENSE);
    assign wr_esense = epirq_reg_hit(reg_wr, reg_addr, `EPIRQ_OFS_EXT_SENSE);
    assign wr_mask = epirq_reg_hit(reg_wr, reg_addr, `EPIRQ_OFS_IRQ_MASK);
    assign wr_status = epirq_reg_hit(reg_wr, reg_addr, `EPIRQ_OFS_IRQ_STATUS);
    assign wr_ext = epirq_reg_hit(reg_wr, reg_addr, `EPIRQ_OFS_EXT_FLAGS);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Pins are asynchronous to sys_clk; two
    // flops trade two cycles for safety
    // Port pins, level sensed
    epirq_sync #(.W(`EPIRQ_NUM_PORT)) u_port_sync
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(port_interrupt_pins),
        .sync_out(port_sync)
    );

    // External pins, edge or level sensed
    epirq_sync #(.W(`EPIRQ_NUM_EXT)) u_ext_sync
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(ext_request_pins),
        .sync_out(ext_sync)
    );

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Writes land at the strobe edge
    // Enable register; no standby input, so nothing but reset or a write clears it
    // A zero bit keeps its pin off the group flag
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_pin_irq_enable <= `EPIRQ_RST_16; // [R02]
        end
        else if (wr_enable)
        begin
            port_pin_irq_enable <= reg_wdata; // [R01]
        end
    end

    // Port pin sense bits
    // A one makes the high level the request
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_sense_control <= `EPIRQ_RST_16; // [R15]
        end
        else if (wr_psense)
        begin
            port_sense_control <= reg_wdata;
        end
    end

    // External pin sense fields
    // Pin n owns bits 2n+1:2n
    // Code 11 is kept but never flags
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_sense_control <= `EPIRQ_RST_12; // [R16]
        end
        else if (wr_esense)
        begin
            ext_sense_control <= reg_wdata[11:0];
        end
    end

    // Interrupt mask
    // Resets closed, so irq starts quiet
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_mask <= `EPIRQ_RST_8;
        end
        else if (wr_mask)
        begin
            irq_mask <= reg_wdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Port group flags
    // ----------------------------------------------------------------
    // Sense 1 means high is a request, 0 means low
    assign port_active = port_pin_irq_enable & ~(port_sync ^ port_sense_control); // [R01] [R15]
    // Gating by the enable is why unused pins must stay disabled [R03]
    // No latching: a group flag drops
    // once every pin of the group lets go

    // Group flags are registered for a clean read value
    // Which pin asked is not kept, only the OR
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_group_low_flag <= 1'b0; // [R14]
            port_group_high_flag <= 1'b0;
        end
        else
        begin
            port_group_low_flag <= |port_active[7:0]; // [R05] [R17]
            port_group_high_flag <= |port_active[15:8]; // [R06] [R17]
        end
    end

    // ----------------------------------------------------------------
    // External request flags
    // ----------------------------------------------------------------
    // Edge latches need this clear
    // Only a written zero clears; ones are ignored. The read-before-clear
    // order is left to software. [R08] [R09]
    assign ext_clear = wr_ext ? ~reg_wdata[5:0] : 6'h00;
    // A clear of a level-mode pin is undone
    // while the pin stays low

    // One detector per pin
    genvar g;
    generate
        for (g = 0; g < `EPIRQ_NUM_EXT; g = g + 1)
        begin : g_ext
            epirq_ext_det u_det
            (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .pin(ext_sync[g]),
                .sense(ext_sense_control[2*g +: 2]),
                .clear(ext_clear[g]), // [R10]
                .flag(ext_pin_flags[g]) // [R07]
            );
        end
    endgenerate

    // Group bits are not writable; only the low six bits take writes
    // Bit 7 low group, bit 6 high group
    assign ext_pin_request_flags = {port_group_low_flag, port_group_high_flag,
                                    ext_pin_flags}; // [R04]

    // ----------------------------------------------------------------
    // Module request flags
    // ----------------------------------------------------------------
    // Follows the sources; no write path at all
    // The source clears its own cause
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            module_request_flags <= `EPIRQ_RST_8; // [R14]
        end
        else
        begin
            module_request_flags <= {ir_transmit_req, ir_break_req, ir_receive_req,
                                     ir_error_req, dma_end_req}; // [R11] [R12] [R13] [R18]
        end
    end

    // ----------------------------------------------------------------
    // Sticky interrupt status
    // ----------------------------------------------------------------
    // Previous views for rising-edge event detection
    // A flag that stays high raises no second event
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_ext_view <= `EPIRQ_RST_8;
            prev_mod_view <= `EPIRQ_RST_8;
        end
        else
        begin
            prev_ext_view <= ext_pin_request_flags;
            prev_mod_view <= module_request_flags;
        end
    end

    // Low four bits: group low, group high, any external, any module.
    // Upper bits stay zero. New events win over write-one-to-clear.
    // So an event between read and clear
    // is never lost
    always_comb
    begin
        next_irq_status = irq_status;
        if (wr_status)
        begin
            next_irq_status = irq_status & ~reg_wdata[7:0];
        end
        next_irq_status[0] = next_irq_status[0] | (port_group_low_flag & ~prev_ext_view[7]);
        next_irq_status[1] = next_irq_status[1] | (port_group_high_flag & ~prev_ext_view[6]);
        next_irq_status[2] = next_irq_status[2] | (|(ext_pin_flags & ~prev_ext_view[5:0]));
        next_irq_status[3] = next_irq_status[3] | (|(module_request_flags & ~prev_mod_view));
        next_irq_status[7:4] = 4'h0;
    end

    // Status register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_status <= `EPIRQ_RST_8;
        end
        else
        begin
            irq_status <= next_irq_status;
        end
    end

    // Level output while any unmasked status bit is set
    // Masking hides a bit from irq, not reads
    assign irq = |(irq_status & irq_mask);

    // ----------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------------------------------
    // Idle cycles return zero, never stale data
    // A read has no side effect on any flag
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= `EPIRQ_RST_16;
        end
        else if (!reg_rd)
        begin
            reg_rdata <= `EPIRQ_RST_16; // Data stands only in the cycle after
        end
        else
        begin
            // Narrow registers read zero above
            unique case (reg_addr)
                `EPIRQ_OFS_PORT_SENSE: reg_rdata <= port_sense_control;
                `EPIRQ_OFS_EXT_SENSE: reg_rdata <= {4'h0, ext_sense_control};
                `EPIRQ_OFS_PIN_ENABLE: reg_rdata <= port_pin_irq_enable;
                `EPIRQ_OFS_EXT_FLAGS: reg_rdata <= {8'h00, ext_pin_request_flags};
                `EPIRQ_OFS_MOD_FLAGS: reg_rdata <= {8'h00, module_request_flags};
                `EPIRQ_OFS_IRQ_STATUS: reg_rdata <= {8'h00, irq_status};
                `EPIRQ_OFS_IRQ_MASK: reg_rdata <= {8'h00, irq_mask};
                default: reg_rdata <= `EPIRQ_RST_16; // Unmapped reads zero
            endcase
        end
    end

endmodule

// file: epirq_props.sv
// Checker for the pin interrupt flag block
`timescale 1ns/1ps
`include "epirq_params.svh"
module epirq_props
    import epirq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [`EPIRQ_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Pins and module lines
    input wire logic [15:0] port_interrupt_pins,
    input wire logic [5:0] ext_request_pins,
    input wire logic [3:0] dma_end_req,
    input wire logic ir_transmit_req,
    input wire logic ir_break_req,
    input wire logic ir_receive_req,
    input wire logic ir_error_req,
    // Interrupt
    input wire logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Shadows of the enable and sense settings
    // ----------------------------------------
    logic [15:0] sh_en; // Enable bits
    logic [15:0] sh_ps; // Port sense bits
    logic [11:0] sh_es; // External sense pairs
    logic [21:0] last_pins; // Pins one cycle back
    logic [3:0] quiet; // Cycles since pins or settings moved
    logic [15:0] match; // Enabled pins at their active level
    logic [5:0] lvl_msk; // Pins in level or reserved mode
    logic [5:0] lvl_val; // Their expected flags
    wire rd_ext = reg_rd && reg_addr == `EPIRQ_OFS_EXT_FLAGS;
    wire rd_mod = reg_rd && reg_addr == `EPIRQ_OFS_MOD_FLAGS;
    wire [7:0] mod_in = {ir_transmit_req, ir_break_req, ir_receive_req, ir_error_req, dma_end_req};
    assign match = sh_en & ~(port_interrupt_pins ^ sh_ps);
    // Level mode flag mirrors the low pin, reserved mode never flags
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            lvl_msk[i] = sh_es[2*i+1];
            lvl_val[i] = !sh_es[2*i] && !ext_request_pins[i];
        end
    end
    // Track software writes
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sh_en <= 16'h0000;
            sh_ps <= 16'h0000;
            sh_es <= 12'h000;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `EPIRQ_OFS_PIN_ENABLE)
                sh_en <= reg_wdata;
            if (reg_addr == `EPIRQ_OFS_PORT_SENSE)
                sh_ps <= reg_wdata;
            if (reg_addr == `EPIRQ_OFS_EXT_SENSE)
                sh_es <= reg_wdata[11:0];
        end
    end
    // Settle counter: flags lag pins by the synchroniser, so wait it out
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            quiet <= 4'h0;
            last_pins <= 22'h000000;
        end
        else
        begin
            last_pins <= {ext_request_pins, port_interrupt_pins};
            if (reg_wr || last_pins != {ext_request_pins, port_interrupt_pins})
                quiet <= 4'h0;
            else if (quiet != 4'hF)
                quiet <= quiet + 4'h1;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_EN_READ:
        assert property (reg_rd && reg_addr == `EPIRQ_OFS_PIN_ENABLE |=> reg_rdata == $past(sh_en))
        else $error("Enable register read back wrong");
    AST_MOD_FLAGS:
        assert property (rd_mod && $past(rst_n) |=> reg_rdata[7:0] == $past(mod_in, 2))
        else $error("Module flags do not follow their sources");
    AST_MOD_UPPER:
        assert property (rd_mod |=> reg_rdata[15:8] == 8'h00)
        else $error("Module flag upper byte not zero");
    AST_EXT_UPPER:
        assert property (rd_ext |=> reg_rdata[15:8] == 8'h00)
        else $error("External flag upper byte not zero");
    AST_GRP_LOW:
        assert property (rd_ext && quiet > 4'h3 |=> reg_rdata[7] == $past(|match[7:0]))
        else $error("Low group flag wrong");
    AST_GRP_HIGH:
        assert property (rd_ext && quiet > 4'h3 |=> reg_rdata[6] == $past(|match[15:8]))
        else $error("High group flag wrong");
    AST_EXT_LEVEL:
        assert property (rd_ext && quiet > 4'h3
            |=> ((reg_rdata[5:0] ^ $past(lvl_val)) & $past(lvl_msk)) == 6'h00)
        else $error("Level or reserved pin flag wrong");
    AST_RESET_CLEAR:
        assert property ($rose(rst_n) |-> reg_rdata == 16'h0000 && !irq)
        else $error("Outputs not clear after reset");
    cover property (rd_ext && quiet > 4'h3 && |match);
    cover property (irq);
    cover property (reg_wr && reg_addr == `EPIRQ_OFS_EXT_FLAGS);
endmodule

// file: epirq_src_model.sv
// Model of the outside sources driving the request pins
`timescale 1ns/1ps
module epirq_src_model
(
    // Clock
    input wire logic sys_clk,
    // Levels asked for by the bench
    input wire logic [15:0] port_set,
    input wire logic [5:0] ext_set,
    input wire logic [7:0] mod_set,
    // Pins idle high, module lines idle low
    output logic [15:0] port_pins = 16'hFFFF,
    output logic [5:0] ext_pins = 6'h3F,
    output logic [7:0] mod_lines = 8'h00
);
    // Sources move just after the edge, like any synchronous neighbour
    always @(posedge sys_clk)
    begin
        port_pins <= port_set;
        ext_pins <= ext_set;
        mod_lines <= mod_set;
    end
endmodule

// file: tb_epirq_top.sv
// Self-checking bench for the pin interrupt flag block
`timescale 1ns/1ps
`include "epirq_params.svh"
module tb_epirq_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [`EPIRQ_ADDR_W-1:0] reg_addr = '0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic irq;
    logic [15:0] port_set = 16'hFFFF; // Port pins idle high
    logic [5:0] ext_set = 6'h3F;
    logic [7:0] mod_set = 8'h00;
    logic [15:0] port_pins;
    logic [5:0] ext_pins;
    logic [7:0] mod_lines;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    logic [15:0] v;
    // ----------------------------------------
    // Instances
    // ----------------------------------------
    epirq_src_model epirq_src_model_i (.sys_clk(sys_clk), .port_set(port_set),
        .ext_set(ext_set), .mod_set(mod_set), .port_pins(port_pins),
        .ext_pins(ext_pins), .mod_lines(mod_lines));
    epirq_top epirq_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .port_interrupt_pins(port_pins), .ext_request_pins(ext_pins),
        .dma_end_req(mod_lines[3:0]), .ir_error_req(mod_lines[4]),
        .ir_receive_req(mod_lines[5]), .ir_break_req(mod_lines[6]),
        .ir_transmit_req(mod_lines[7]), .irq(irq));
    initial
        forever #10 sys_clk = ~sys_clk;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [`EPIRQ_ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rchk(input string name, input logic [`EPIRQ_ADDR_W-1:0] a,
        input logic [15:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk(name, reg_rdata, exp);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Hang guard, well above the roughly 150 cycles the tests need
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            error_cnt++;
            final_report();
        end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        rchk("enable", `EPIRQ_OFS_PIN_ENABLE, 16'h0000);
        rchk("ext flags", `EPIRQ_OFS_EXT_FLAGS, 16'h0000);
        rchk("mod flags", `EPIRQ_OFS_MOD_FLAGS, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 2; i++)
        begin
            v = i ? 16'h5A3C : 16'hA5C3;
            wr(`EPIRQ_OFS_PIN_ENABLE, v);
            rchk("enable", `EPIRQ_OFS_PIN_ENABLE, v);
        end
        // Unmapped place is ignored and reads zero
        wr(5'h1C, 16'hFFFF);
        rchk("unmapped", 5'h1C, 16'h0000);
        rchk("enable kept", `EPIRQ_OFS_PIN_ENABLE, 16'h5A3C);
        $display("test enable done");
        wr(`EPIRQ_OFS_PIN_ENABLE, 16'h0008);
        port_set <= 16'hFFF7;
        repeat (6) @(posedge sys_clk);
        rchk("group low", `EPIRQ_OFS_EXT_FLAGS, 16'h0080);
        wr(`EPIRQ_OFS_PIN_ENABLE, 16'h0000);
        repeat (4) @(posedge sys_clk);
        rchk("gated", `EPIRQ_OFS_EXT_FLAGS, 16'h0000);
        wr(`EPIRQ_OFS_PORT_SENSE, 16'h1000);
        wr(`EPIRQ_OFS_PIN_ENABLE, 16'h1000);
        port_set <= 16'hFFFF;
        repeat (6) @(posedge sys_clk);
        rchk("group high", `EPIRQ_OFS_EXT_FLAGS, 16'h0040);
        port_set <= 16'hEFFF;
        repeat (6) @(posedge sys_clk);
        rchk("group idle", `EPIRQ_OFS_EXT_FLAGS, 16'h0000);
        wr(`EPIRQ_OFS_PIN_ENABLE, 16'h0000);
        $display("test groups done");
        // Pins 0..5: fall, rise, low, reserved, rise, fall
        wr(`EPIRQ_OFS_EXT_SENSE, 16'h01E4);
        ext_set <= 6'b010000;
        repeat (6) @(posedge sys_clk);
        rchk("ext step1", `EPIRQ_OFS_EXT_FLAGS, 16'h0025);
        ext_set <= 6'b110110;
        repeat (6) @(posedge sys_clk);
        rchk("ext step2", `EPIRQ_OFS_EXT_FLAGS, 16'h0023);
        wr(`EPIRQ_OFS_EXT_FLAGS, 16'h00FF);
        rchk("ones kept", `EPIRQ_OFS_EXT_FLAGS, 16'h0023);
        wr(`EPIRQ_OFS_EXT_FLAGS, 16'h00FE);
        rchk("one cleared", `EPIRQ_OFS_EXT_FLAGS, 16'h0022);
        wr(`EPIRQ_OFS_EXT_FLAGS, 16'h0000);
        rchk("all cleared", `EPIRQ_OFS_EXT_FLAGS, 16'h0000);
        $display("test ext pins done");
        for (int i = 0; i < 8; i++)
        begin
            mod_set <= 8'h01 << i;
            repeat (2) @(posedge sys_clk);
            rchk("mod flag", `EPIRQ_OFS_MOD_FLAGS, 16'h0001 << i);
        end
        mod_set <= 8'h00;
        wr(`EPIRQ_OFS_MOD_FLAGS, 16'h00FF);
        rchk("mod write", `EPIRQ_OFS_MOD_FLAGS, 16'h0000);
        $display("test module flags done");
        // Every source kind rose once, mask still closed
        rchk("status", `EPIRQ_OFS_IRQ_STATUS, 16'h000F);
        chk("irq masked", {15'h0, irq}, 16'h0000);
        wr(`EPIRQ_OFS_IRQ_MASK, 16'h0008);
        @(negedge sys_clk);
        chk("irq open", {15'h0, irq}, 16'h0001);
        wr(`EPIRQ_OFS_IRQ_STATUS, 16'h000F);
        @(negedge sys_clk);
        chk("irq clear", {15'h0, irq}, 16'h0000);
        rchk("status clear", `EPIRQ_OFS_IRQ_STATUS, 16'h0000);
        $display("test interrupt done");
        final_report();
    end
endmodule
bind epirq_top epirq_props epirq_props_i (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .port_interrupt_pins, .ext_request_pins, .dma_end_req,
    .ir_transmit_req, .ir_break_req, .ir_receive_req, .ir_error_req, .irq);
